/* rtl/mufm_pkg.sv */
// constants, register map and types of the modem uart control block
// assumes one system clock; the register port is driven by logic on that clock
// Overview of operation
// - bit 0 of the send-request register drives the request-to-send pin, reset zero
// - receive fifo entry count reads back in five bits, zero after reset
// - transmit fifo byte count reads back in five bits, zero after reset
// - a mask bit of one keeps its status bit off the alert pin
// - mask bits sit at the same positions as their status bits
// - masking never stops a source from setting its summary flag
// - all implemented mask bits set at reset; bits 15..13 and 8 read zero
// - gap with gap-reset bit set returns the frame monitor to preamble
// - carrier low with carrier-reset bit set returns the frame monitor to preamble
// - with store-every-char set every received character enters the receive fifo
// - otherwise, with monitor on, store from first byte after good preamble
// - frame monitor runs only while config bit 12 is set, cleared at reset
// - config resets with gap reset and carrier reset set, filter and monitor clear
// - with auto drop set, finished transmission clears the send request
// - reading the receive data register returns and pops the fifo head
package mufm_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;
    localparam int          CHAR_W          = 8;
    localparam int          FIFO_DEPTH      = 16;
    localparam int          COUNT_W         = 6;
    // register offsets
    localparam logic [7:0]  ADDR_RX_DATA    = 8'h81;
    localparam logic [7:0]  ADDR_TX_DATA    = 8'h82;
    localparam logic [7:0]  ADDR_SEND_REQ   = 8'h84;
    localparam logic [7:0]  ADDR_RX_LEVEL   = 8'h85;
    localparam logic [7:0]  ADDR_TX_LEVEL   = 8'h86;
    localparam logic [7:0]  ADDR_ALERT_MASK = 8'h87;
    localparam logic [7:0]  ADDR_LINK_CFG   = 8'h88;
    // reset values and implemented bits
    localparam logic [15:0] MASK_RESET      = 16'h1eff;
    localparam logic [15:0] MASK_IMPL       = 16'h1eff;
    localparam logic [15:0] CFG_RESET       = 16'hc430;
    localparam logic [15:0] ZERO_WORD       = 16'h0000;
    // field positions
    localparam int          SEND_REQ_BIT    = 0;
    localparam int          CFG_GAP_RST     = 15;
    localparam int          CFG_CD_RST      = 14;
    localparam int          CFG_STORE_ALL   = 13;
    localparam int          CFG_MON_EN      = 12;
    localparam int          CFG_AUTO_DROP   = 4;
    // frame monitor
    localparam logic [7:0]  PREAMBLE_CHAR   = 8'hff;
    localparam logic [2:0]  MIN_PREAMBLE    = 3'h2;
    localparam logic [2:0]  PREAMBLE_SAT    = 3'h7;

    typedef enum logic [0:0] {MON_PREAMBLE, MON_FRAME} mufm_mon_t;
endpackage : mufm_pkg

/* rtl/mufm_top.sv */
// modem uart control: send request, fifo levels, alert mask, frame monitor
// assumes a receiver and transmitter on sys_clk; carrier detect comes from a pin
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// parameterised fifo, flip-flop storage, valid/ready on both sides
module mufm_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [W-1:0]     in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [W-1:0]     out_data,
    output logic [$clog2(D):0]    count
);
    localparam int PW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [PW-1:0] wp_q;
    logic [PW-1:0] rp_q;
    logic [PW:0]   cnt_q;
    logic          push;
    logic          pop;

    // honest full/empty straight from the occupancy count
    assign in_ready  = (cnt_q != (PW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];
    assign count     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // storage written only on push, no reset needed for data
    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end

    // pointers and count
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= wp_q + 1'b1;
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : mufm_fifo

////////////////////////////////////////////////////////////////////////////////
module mufm_top
    import mufm_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    // register port
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_rvalid,
    // receiver side
    input  wire logic              rx_char_valid,
    output logic                   rx_char_ready,
    input  wire logic [CHAR_W-1:0] rx_char,
    input  wire logic              gap_event,
    input  wire logic              carrier_detect,
    // transmitter side
    output logic                   tx_char_valid,
    input  wire logic              tx_char_ready,
    output logic      [CHAR_W-1:0] tx_char,
    input  wire logic              tx_frame_done,
    output logic                   tx_fifo_space,
    // status and pins
    input  wire logic [DATA_W-1:0] modem_status,
    output logic                   modem_alert_flags,
    output logic                   alert_pin,
    output logic                   modem_rts
);
    logic              rst_s1_q;
    logic              rst_n;
    logic              cd_s1_q;
    logic              cd_s2_q;
    logic              send_req_q;
    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] cfg_q;
    mufm_mon_t         mon_q;
    logic [2:0]        pre_cnt_q;
    logic [DATA_W-1:0] rdata_q;
    logic              rvalid_q;
    logic              mon_en;
    logic              mon_clr;
    logic              good_pre;
    logic              keep;
    logic              rx_push;
    logic              rxf_ready;
    logic              rxf_valid;
    logic              rx_pop;
    logic [CHAR_W-1:0] rxf_data;
    logic [4:0]        rx_cnt;
    logic [4:0]        tx_cnt;
    logic              tx_push;

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = reg_wr && (reg_addr == a);
    endfunction : wr_at

    function automatic logic [15:0] level_word(input logic [4:0] c);
        level_word = ZERO_WORD | 16'(c);
    endfunction : level_word

    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops; constants only under async reset
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // carrier detect arrives from a pin, two flops before use
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cd_s1_q <= 1'b0;
            cd_s2_q <= 1'b0;
        end
        else
        begin
            cd_s1_q <= carrier_detect;
            cd_s2_q <= cd_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // send request: software write wins over the automatic drop in one cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            send_req_q <= 1'b0;
        else if (wr_at(ADDR_SEND_REQ))
            send_req_q <= reg_wdata[SEND_REQ_BIT];
        else if (tx_frame_done && cfg_q[CFG_AUTO_DROP])
            send_req_q <= 1'b0;
    end
    assign modem_rts = send_req_q;

    // alert mask, reserved positions never stored
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mask_q <= MASK_RESET;
        else if (wr_at(ADDR_ALERT_MASK))
            mask_q <= reg_wdata & MASK_IMPL;
    end

    // link configuration, all sixteen bits writable
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cfg_q <= CFG_RESET;
        else if (wr_at(ADDR_LINK_CFG))
            cfg_q <= reg_wdata;
    end

    // pin sees only unmasked sources; summary ignores the mask
    assign alert_pin         = |(modem_status & MASK_IMPL & ~mask_q);
    assign modem_alert_flags = |(modem_status & MASK_IMPL);

    ////////////////////////////////////////////////////////////////////////////
    // frame monitor; a clear takes priority over any character that cycle
    assign mon_en   = cfg_q[CFG_MON_EN];
    assign mon_clr  = !mon_en
                    || (cfg_q[CFG_GAP_RST] && gap_event)
                    || (cfg_q[CFG_CD_RST] && !cd_s2_q);
    assign good_pre = (rx_char != PREAMBLE_CHAR) && (pre_cnt_q >= MIN_PREAMBLE);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mon_q     <= MON_PREAMBLE;
            pre_cnt_q <= 3'h0;
        end
        else if (mon_clr)
        begin
            mon_q     <= MON_PREAMBLE;
            pre_cnt_q <= 3'h0;
        end
        else if (rx_char_valid && rx_char_ready)
        begin
            case (mon_q)
                MON_PREAMBLE:
                begin
                    if (rx_char == PREAMBLE_CHAR)
                    begin
                        if (pre_cnt_q != PREAMBLE_SAT)
                            pre_cnt_q <= pre_cnt_q + 3'h1;
                    end
                    else if (good_pre)
                        mon_q <= MON_FRAME;
                    else
                        pre_cnt_q <= 3'h0;
                end
                MON_FRAME:
                    mon_q <= MON_FRAME;
                default:
                    mon_q <= MON_PREAMBLE;
            endcase
        end
    end

    // character filter; with the monitor off and no filter, everything is kept
    assign keep = cfg_q[CFG_STORE_ALL]
               || !mon_en
               || (mon_q == MON_FRAME)
               || ((mon_q == MON_PREAMBLE) && good_pre);
    assign rx_push       = rx_char_valid && keep;
    // dropped characters are consumed even when the fifo is full
    assign rx_char_ready = rxf_ready || !keep;

    ////////////////////////////////////////////////////////////////////////////
    // fifos; receive side drains by register reads, transmit by the transmitter
    assign rx_pop  = reg_rd && (reg_addr == ADDR_RX_DATA) && rxf_valid;
    assign tx_push = wr_at(ADDR_TX_DATA);

    mufm_fifo #(.W(CHAR_W), .D(FIFO_DEPTH)) u_rx_fifo (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (rx_push),
        .in_ready  (rxf_ready),
        .in_data   (rx_char),
        .out_valid (rxf_valid),
        .out_ready (rx_pop),
        .out_data  (rxf_data),
        .count     (rx_cnt)
    );

    mufm_fifo #(.W(CHAR_W), .D(FIFO_DEPTH)) u_tx_fifo (
        .clk       (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (tx_push),
        .in_ready  (tx_fifo_space),
        .in_data   (reg_wdata[CHAR_W-1:0]),
        .out_valid (tx_char_valid),
        .out_ready (tx_char_ready),
        .out_data  (tx_char),
        .count     (tx_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q  <= ZERO_WORD;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= reg_rd;
            if (reg_rd)
            begin
                case (reg_addr)
                    ADDR_RX_DATA:    rdata_q <= rxf_valid ? (ZERO_WORD | 16'(rxf_data))
                                                          : ZERO_WORD;
                    ADDR_SEND_REQ:   rdata_q <= ZERO_WORD | 16'(send_req_q);
                    ADDR_RX_LEVEL:   rdata_q <= level_word(rx_cnt);
                    ADDR_TX_LEVEL:   rdata_q <= level_word(tx_cnt);
                    ADDR_ALERT_MASK: rdata_q <= mask_q;
                    ADDR_LINK_CFG:   rdata_q <= cfg_q;
                    default:         rdata_q <= ZERO_WORD;
                endcase
            end
        end
    end
    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_rx_read;
        reg_rd && (reg_addr == ADDR_RX_DATA) && rxf_valid && !rx_push;
    endsequence

    sequence s_frame_start;
        !mon_clr && rx_char_valid && rx_char_ready && !cfg_q[CFG_STORE_ALL]
        && (mon_q == MON_PREAMBLE) && good_pre;
    endsequence

    a_rts_follows_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_at(ADDR_SEND_REQ) |=> (modem_rts == $past(reg_wdata[SEND_REQ_BIT])))
        else $error("send request did not follow its write");

    a_rts_auto_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        tx_frame_done && cfg_q[CFG_AUTO_DROP] && !wr_at(ADDR_SEND_REQ) |=> !modem_rts)
        else $error("send request not dropped after transmission");

    a_alert_mask_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((modem_status & ~mask_q & MASK_IMPL) == ZERO_WORD) |-> !alert_pin)
        else $error("masked source reached the alert pin");

    a_summary_unmasked: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (modem_status[0] || modem_status[12]) |-> modem_alert_flags)
        else $error("summary flag suppressed by mask");

    a_mask_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (mask_q & ~MASK_IMPL) == ZERO_WORD)
        else $error("reserved mask bit set");

    a_gap_reset_mon: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_q[CFG_GAP_RST] && gap_event |=> (mon_q == MON_PREAMBLE) && (pre_cnt_q == 3'h0))
        else $error("gap did not reset frame monitor");

    a_cd_reset_mon: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_q[CFG_CD_RST] && !cd_s2_q |=> (mon_q == MON_PREAMBLE))
        else $error("carrier loss did not reset frame monitor");

    a_monitor_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !mon_en [*2] |-> (mon_q == MON_PREAMBLE))
        else $error("frame monitor ran while disabled");

    a_store_every: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_q[CFG_STORE_ALL] && rx_char_valid && rxf_ready && !rx_pop
        |=> rx_cnt == $past(rx_cnt) + 5'h1)
        else $error("character not stored with filter off");

    a_frame_first_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_frame_start |-> rx_push ##1 (mon_q == MON_FRAME) || mon_clr)
        else $error("delimiter not stored at frame start");

    a_rx_read_pop: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_rx_read |=> reg_rvalid && (rx_cnt == $past(rx_cnt) - 5'h1)
                      && (reg_rdata == (ZERO_WORD | 16'($past(rxf_data)))))
        else $error("receive read did not return and pop head");

    a_level_in_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rvalid && ($past(reg_addr) == ADDR_RX_LEVEL) |-> reg_rdata <= 16'h0010)
        else $error("receive level out of range");
endmodule : mufm_top

`default_nettype wire

/* tb/mufm_line_model.sv */
// transmitter-side model: takes bytes off the tx fifo, can stall, reports frame end
// assumes the block's tx stream contract; runs on sys_clk with the board reset
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module mufm_line_model (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       stall,
    input  wire logic       tx_char_valid,
    input  wire logic [7:0] tx_char,
    output logic            tx_char_ready,
    output logic            tx_frame_done,
    output logic      [7:0] sink_count,
    output logic      [7:0] sink_last
);
    logic pop_q;

    // ready is a plain level; a stalled line lets the fifo back up
    assign tx_char_ready = !stall;

    // count every byte the line takes and keep the last one
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pop_q      <= 1'b0;
            sink_count <= 8'h00;
            sink_last  <= 8'h00;
        end
        else
        begin
            pop_q <= tx_char_valid && tx_char_ready;
            if (tx_char_valid && tx_char_ready)
            begin
                sink_count <= sink_count + 8'h01;
                sink_last  <= tx_char;
            end
        end
    end

    // frame ends once the last queued byte has gone out, one-cycle pulse
    assign tx_frame_done = pop_q && !tx_char_valid;
endmodule : mufm_line_model
`default_nettype wire

/* tb/tb_modem_uart_ctrl_frame_monitor.sv */
// self-checking bench: register strobes, receive feed, transmit sink model
// assumes mufm_pkg, mufm_top and mufm_line_model compiled before this file
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module tb_modem_uart_ctrl_frame_monitor
    import mufm_pkg::*;
;
    logic              sys_clk, nrst, reg_wr, reg_rd, reg_rvalid;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, modem_status;
    logic              rx_char_valid, rx_char_ready, gap_event, carrier_detect;
    logic [CHAR_W-1:0] rx_char, tx_char;
    logic              tx_char_valid, tx_char_ready, tx_frame_done, tx_fifo_space;
    logic              modem_alert_flags, alert_pin, modem_rts, sink_stall;
    logic [7:0]        sink_count, sink_last;
    int                err_count;
    int                samples_checked;

    mufm_top uut (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .rx_char_valid(rx_char_valid),
        .rx_char_ready(rx_char_ready), .rx_char(rx_char), .gap_event(gap_event),
        .carrier_detect(carrier_detect), .tx_char_valid(tx_char_valid),
        .tx_char_ready(tx_char_ready), .tx_char(tx_char), .tx_frame_done(tx_frame_done),
        .tx_fifo_space(tx_fifo_space), .modem_status(modem_status),
        .modem_alert_flags(modem_alert_flags), .alert_pin(alert_pin), .modem_rts(modem_rts));

    mufm_line_model line (.sys_clk(sys_clk), .nrst(nrst), .stall(sink_stall),
        .tx_char_valid(tx_char_valid), .tx_char(tx_char), .tx_char_ready(tx_char_ready),
        .tx_frame_done(tx_frame_done), .sink_count(sink_count), .sink_last(sink_last));

    // 250 MHz system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // one write strobe; idle edge first so strobes never toggle twice in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #1 reg_wr = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
    endtask : wr

    // one read strobe; answer is valid right after the edge that takes it
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        #1 reg_rd = 1'b1;
        reg_addr  = a;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        check({15'h0000, reg_rvalid}, 16'h0001);
        check(reg_rdata, exp);
    endtask : rd_chk

    // hold the character until the block takes it, bounded wait
    task automatic send(input logic [7:0] s[$]);
        int n;
        foreach (s[i])
        begin
            @(posedge sys_clk);
            #1 rx_char_valid = 1'b1;
            rx_char = s[i];
            n = 0;
            while (rx_char_ready !== 1'b1 && n < 50)
            begin
                @(posedge sys_clk);
                #1 n++;
            end
            check({15'h0000, rx_char_ready}, 16'h0001);
            @(posedge sys_clk);
            #1 rx_char_valid = 1'b0;
            rx_char = ~s[i];
        end
    endtask : send

    task automatic gap_pulse;
        @(posedge sys_clk);
        #1 gap_event = 1'b1;
        @(posedge sys_clk);
        #1 gap_event = 1'b0;
    endtask : gap_pulse

    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the tests need a few hundred cycles, so 20000 means a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        finish_test();
    end

    // main sequence
    initial
    begin
        int n;
        err_count = 0;
        samples_checked = 0;
        nrst = 1'b0;
        {reg_wr, reg_rd, rx_char_valid, gap_event, sink_stall} = 5'h00;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        rx_char = 8'h00;
        carrier_detect = 1'b1;
        modem_status = 16'h0000;
        repeat (12) @(posedge sys_clk);
        #1 nrst = 1'b1;
        repeat (3) @(posedge sys_clk);
        // reset values and unmapped address
        rd_chk(ADDR_SEND_REQ, 16'h0000);
        rd_chk(ADDR_RX_LEVEL, 16'h0000);
        rd_chk(ADDR_TX_LEVEL, 16'h0000);
        rd_chk(ADDR_ALERT_MASK, 16'h1eff);
        rd_chk(ADDR_LINK_CFG, 16'hc430);
        rd_chk(8'h80, 16'h0000);
        check({15'h0000, modem_rts}, 16'h0000);
        $display("test reset values done");
        // send request bit, reserved bits and read-only level
        wr(ADDR_SEND_REQ, 16'hffff);
        check({15'h0000, modem_rts}, 16'h0001);
        rd_chk(ADDR_SEND_REQ, 16'h0001);
        wr(ADDR_SEND_REQ, 16'h0000);
        check({15'h0000, modem_rts}, 16'h0000);
        wr(ADDR_RX_LEVEL, 16'h0005);
        rd_chk(ADDR_RX_LEVEL, 16'h0000);
        wr(ADDR_ALERT_MASK, 16'hffff);
        rd_chk(ADDR_ALERT_MASK, 16'h1eff);
        $display("test register access done");
        // each alert source, masked and unmasked
        for (int b = 0; b < 13; b++)
        begin
            if (b == 8)
                continue;
            modem_status = 16'h0001 << b;
            wr(ADDR_ALERT_MASK, 16'h1eff & ~(16'h0001 << b));
            check({15'h0000, alert_pin}, 16'h0001);
            wr(ADDR_ALERT_MASK, 16'h1eff);
            check({15'h0000, alert_pin}, 16'h0000);
            check({15'h0000, modem_alert_flags}, 16'h0001);
        end
        modem_status = 16'h0100;
        wr(ADDR_ALERT_MASK, 16'h0000);
        check({15'h0000, alert_pin}, 16'h0000);
        modem_status = 16'h0000;
        $display("test alert mask done");
        // store every char even with the monitor waiting for preamble
        wr(ADDR_LINK_CFG, 16'hf430);
        send('{8'h12, 8'h34});
        rd_chk(ADDR_RX_LEVEL, 16'h0002);
        rd_chk(ADDR_RX_DATA, 16'h0012);
        rd_chk(ADDR_RX_LEVEL, 16'h0001);
        rd_chk(ADDR_RX_DATA, 16'h0034);
        $display("test store all done");
        // frame filter: junk dropped, delimiter is the first stored byte
        wr(ADDR_LINK_CFG, 16'hd430);
        send('{8'h55, 8'hff, 8'hff, 8'h82, 8'h07});
        rd_chk(ADDR_RX_LEVEL, 16'h0002);
        rd_chk(ADDR_RX_DATA, 16'h0082);
        rd_chk(ADDR_RX_DATA, 16'h0007);
        gap_pulse();
        send('{8'h33});
        rd_chk(ADDR_RX_LEVEL, 16'h0000);
        send('{8'hff, 8'hff, 8'h44});
        carrier_detect = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1 carrier_detect = 1'b1;
        repeat (4) @(posedge sys_clk);
        send('{8'h55});
        rd_chk(ADDR_RX_LEVEL, 16'h0001);
        // reset sources switched off leave the frame running
        wr(ADDR_LINK_CFG, 16'h5430);
        send('{8'hff, 8'hff, 8'h11});
        gap_pulse();
        send('{8'h22});
        rd_chk(ADDR_RX_LEVEL, 16'h0003);
        wr(ADDR_LINK_CFG, 16'h9430);
        carrier_detect = 1'b0;
        repeat (4) @(posedge sys_clk);
        send('{8'h23});
        carrier_detect = 1'b1;
        rd_chk(ADDR_RX_LEVEL, 16'h0004);
        wr(ADDR_LINK_CFG, 16'hc430);
        send('{8'h99});
        rd_chk(ADDR_RX_LEVEL, 16'h0005);
        // drain in arrival order; one read per stored character, then one of the empty fifo
        rd_chk(ADDR_RX_DATA, 16'h0044);
        rd_chk(ADDR_RX_DATA, 16'h0011);
        rd_chk(ADDR_RX_DATA, 16'h0022);
        rd_chk(ADDR_RX_DATA, 16'h0023);
        rd_chk(ADDR_RX_DATA, 16'h0099);
        rd_chk(ADDR_RX_DATA, 16'h0000);
        $display("test frame monitor done");
        // fill the tx fifo past full with the line stalled, then auto drop
        sink_stall = 1'b1;
        for (int i = 0; i < 17; i++)
            wr(ADDR_TX_DATA, 16'(i));
        rd_chk(ADDR_TX_LEVEL, 16'h0010);
        check({15'h0000, tx_fifo_space}, 16'h0000);
        check({15'h0000, tx_char_valid}, 16'h0001);
        wr(ADDR_SEND_REQ, 16'h0001);
        sink_stall = 1'b0;
        n = 0;
        while (modem_rts !== 1'b0 && n < 100)
        begin
            @(posedge sys_clk);
            #1 n++;
        end
        check({15'h0000, modem_rts}, 16'h0000);
        check({sink_count, sink_last}, 16'h100f);
        rd_chk(ADDR_SEND_REQ, 16'h0000);
        rd_chk(ADDR_TX_LEVEL, 16'h0000);
        check({15'h0000, tx_char_valid}, 16'h0000);
        // auto drop off: the send request must survive the end of transmission
        wr(ADDR_LINK_CFG, 16'hc420);
        wr(ADDR_SEND_REQ, 16'h0001);
        wr(ADDR_TX_DATA, 16'h00a5);
        repeat (4) @(posedge sys_clk);
        #1 check({15'h0000, modem_rts}, 16'h0001);
        check({sink_count, sink_last}, 16'h11a5);
        $display("test transmit done");
        finish_test();
    end
endmodule : tb_modem_uart_ctrl_frame_monitor
`default_nettype wire
